// *** core/ttv_cfg.svh ***
/*
 Constants for the tape time tracker and frame validity block: time units,
 frame durations, store sizes, field widths and sync tolerance.
 Assumes it is included once per unit; the guard handles repeats.
*/
// How it works
// RL1 - First error-free header sets the filtered time
// RL2 - Each sync or watchdog adds one frame duration
// RL3 - New time probational until enough agreeing frames
// RL4 - Confirmation count programmable from 1 to 255
// RL5 - Discard time after mismatch limit consecutive frames
// RL6 - After discard, reinitialise and reconfirm fully
// RL7 - Host supplies confirm count and mismatch limit
// RL8 - Deformatter uses one valid tracker time
// RL9 - Deformatter converts time to sample count
// RL10 - Deformatter servos target bit to buffer centre
// RL11 - Lost continuity returns everything to start
// RL12 - Deformatter gates each cycle on five conditions
// RL13 - Up to nine tracks, judged per frame
// RL14 - Verdict made at write, one bit per track
// RL15 - Valid needs valid time and sync on prediction
// RL16 - Sync detection tolerates some bit errors
// RL17 - Parity error count must be below threshold
// RL18 - Global invalid command forces every frame invalid
// RL19 - Probation defers missing-sync frames to next frame
// RL20 - Probation lasts exactly one frame period
// RL21 - Flags stored circularly, presented at readout
// RL22 - Record time code and start address per frame
// RL23 - New read delay applied every four milliseconds
// RL24 - One shared pulse at each frame's first bit
// RL25 - Sync reloads write address counter from controller
// RL26 - Match clears mismatch count; mismatch clears confirm
`ifndef TTV_CFG_SVH
`define TTV_CFG_SVH

`define TTV_NTRK 9
`define TTV_TIME_W 32
`define TTV_ADDR_W 16
`define TTV_CNT_W 8
`define TTV_IDX_W 4
`define TTV_DEPTH 16
`define TTV_SERR_W 4

// Filtered time counts in ticks of this many microseconds
`define TTV_TICK_US 500
`define TTV_FRAME_US_FAST 2500
`define TTV_FRAME_US_MID 5000
`define TTV_FRAME_US_SLOW 10000
`define TTV_STEP_FAST 32'(`TTV_FRAME_US_FAST / `TTV_TICK_US)
`define TTV_STEP_MID 32'(`TTV_FRAME_US_MID / `TTV_TICK_US)
`define TTV_STEP_SLOW 32'(`TTV_FRAME_US_SLOW / `TTV_TICK_US)

// Record rate select codes
`define TTV_RATE_FAST 2'h0
`define TTV_RATE_MID 2'h1
`define TTV_RATE_SLOW 2'h2

// Most sync bit errors still accepted as a sync word
`define TTV_SYNC_ERR_MAX 4'h2

`endif

// *** core/ttv_pkg.sv ***
/*
 Types for the tape time tracker: tracker states, the store entry and the
 frame store record. Assumes ttv_cfg.svh is on the include path.
*/
`default_nettype none
`include "ttv_cfg.svh"
package ttv_pkg;

	// Filtered time life cycle
	typedef enum logic [1:0] {TTV_SEARCH, TTV_PROBATION, TTV_LOCKED} ttv_tstate_t;

	// One circular store entry
	typedef struct packed {
		logic [`TTV_ADDR_W-1:0] addr; // Buffer address of the frame's first bit
		logic [`TTV_TIME_W-1:0] tcode; // Time code of the frame
		logic [`TTV_NTRK-1:0] valid; // Final per-track verdict
	} ttv_entry_t;

	typedef struct packed {
		ttv_entry_t [`TTV_DEPTH-1:0] mem;
	} ttv_store_t;

endpackage : ttv_pkg
`default_nettype wire

// *** core/ttv_frame_store.sv ***
/*
 Circular flip-flop store of frame start address, time code and validity.
 Assumes writes come from the tracker, which owns all pointers.
*/
`default_nettype none
`include "ttv_cfg.svh"
module ttv_frame_store
	import ttv_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ent_we_i,
	input wire logic [`TTV_IDX_W-1:0] ent_idx_i,
	input wire logic [`TTV_ADDR_W-1:0] ent_addr_i,
	input wire logic [`TTV_TIME_W-1:0] ent_time_i,
	input wire logic vld_we_i,
	input wire logic [`TTV_IDX_W-1:0] vld_idx_i,
	input wire logic [`TTV_NTRK-1:0] vld_i,
	input wire logic [`TTV_IDX_W-1:0] rd_idx_i,
	output ttv_entry_t rd_o
);

	ttv_store_t st_ff; // Whole store
	ttv_store_t nxt_st; // Next store

	// Read port is a plain index
	assign rd_o = st_ff.mem[rd_idx_i];

	// Entry and verdict writes; verdict clears on a fresh entry [RL21]
	always_comb begin
		nxt_st = st_ff;
		if (ent_we_i) begin
			nxt_st.mem[ent_idx_i].addr = ent_addr_i; // [RL22]
			nxt_st.mem[ent_idx_i].tcode = ent_time_i; // [RL22]
			nxt_st.mem[ent_idx_i].valid = '0;
		end
		if (vld_we_i) begin
			nxt_st.mem[vld_idx_i].valid = vld_i; // [RL14]
		end
	end

	// Store registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : ttv_frame_store
`default_nettype wire

// *** core/ttv_tracker.sv ***
/*
 Tape time tracker and frame validity judge for one track recovery unit.
 Keeps the filtered time, judges each frame per track as it is written,
 stores verdicts circularly and presents them as frames are read out.
 Assumes all inputs are synchronous to SYS_CLK_I, event inputs are
 one-cycle pulses, and per-frame header results are stable at HDR_STB_I.
*/
`default_nettype none
`include "ttv_cfg.svh"
module ttv_tracker
	import ttv_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic [`TTV_NTRK-1:0] TRACK_EN_I,
	input wire logic [1:0] RATE_SEL_I,
	input wire logic SYNC_DET_I,
	input wire logic WDOG_EXP_I,
	input wire logic WDOG_EN_I,
	input wire logic [`TTV_ADDR_W-1:0] NEXT_SYNC_ADDR_I,
	input wire logic HDR_STB_I,
	input wire logic HDR_OK_I,
	input wire logic [`TTV_TIME_W-1:0] HDR_TIME_I,
	input wire logic FRAME_DONE_I,
	input wire logic [`TTV_NTRK-1:0] SYNC_FOUND_I,
	input wire logic [`TTV_NTRK*`TTV_SERR_W-1:0] SYNC_BIT_ERR_I,
	input wire logic [`TTV_NTRK-1:0] SYNC_ON_TIME_I,
	input wire logic [`TTV_NTRK*`TTV_CNT_W-1:0] PAR_ERR_I,
	input wire logic [`TTV_CNT_W-1:0] PAR_LIMIT_I,
	input wire logic [`TTV_CNT_W-1:0] TIME_CONFIRM_COUNT_I,
	input wire logic [`TTV_CNT_W-1:0] TIME_MISMATCH_LIMIT_I,
	input wire logic GLOBAL_INVALID_I,
	input wire logic PROBATION_EN_I,
	input wire logic CONT_LOST_I,
	input wire logic [`TTV_ADDR_W-1:0] RD_ADDR_I,
	input wire logic DELAY_TICK_I,
	input wire logic [`TTV_ADDR_W-1:0] DELAY_ADDR_I,
	output logic [`TTV_TIME_W-1:0] FILT_TIME_O,
	output logic TIME_VALID_O,
	output logic WR_LOAD_O,
	output logic [`TTV_ADDR_W-1:0] WR_ADDR_O,
	output logic FRAME_START_O,
	output logic [`TTV_NTRK-1:0] FRAME_VALID_O,
	output logic [`TTV_TIME_W-1:0] FRAME_TIME_O,
	output logic [`TTV_ADDR_W-1:0] FRAME_ADDR_O,
	output logic RD_LOAD_O,
	output logic [`TTV_ADDR_W-1:0] RD_ADDR_O
);

	// All tracker state in one record
	typedef struct packed {
		ttv_tstate_t tst; // Filtered time state
		logic [`TTV_TIME_W-1:0] filt; // Filtered time in ticks
		logic [`TTV_CNT_W-1:0] conf; // Agreeing frames so far
		logic [`TTV_CNT_W-1:0] miss; // Consecutive mismatching frames
		logic match; // A header of this frame agreed
		logic [`TTV_ADDR_W-1:0] start; // Start address of frame being written
		logic [`TTV_IDX_W-1:0] wr_ptr; // Next entry to fill
		logic [`TTV_IDX_W-1:0] vld_ptr; // One past last final verdict
		logic [`TTV_IDX_W-1:0] rd_ptr; // Next entry to present
		logic have_prev; // Previous frame awaits its verdict
		logic [`TTV_IDX_W-1:0] prev_idx; // Entry of previous frame
		logic [`TTV_NTRK-1:0] pend_flag; // Tracks on probation
		logic [`TTV_NTRK-1:0] pend_valid; // Tentative verdicts of previous frame
		logic time_valid; // Output copies follow
		logic wr_load;
		logic [`TTV_ADDR_W-1:0] wr_addr;
		logic fstart;
		logic [`TTV_NTRK-1:0] fvalid;
		logic [`TTV_TIME_W-1:0] ftime;
		logic [`TTV_ADDR_W-1:0] faddr;
		logic rd_load;
		logic [`TTV_ADDR_W-1:0] rd_addr;
	} ttv_trk_t;

	ttv_trk_t st_ff; // Registered state
	ttv_trk_t nxt_st; // Next state

	logic [`TTV_TIME_W-1:0] step; // One frame duration in ticks
	logic advance; // Time advance event
	logic [`TTV_NTRK-1:0] sync_seen; // Tolerant sync present
	logic [`TTV_NTRK-1:0] sync_good; // Sync present at predicted place
	logic [`TTV_NTRK-1:0] base_ok; // Time, enable, parity and global checks
	logic [`TTV_NTRK-1:0] cur_valid; // Tentative verdict of this frame
	logic [`TTV_NTRK-1:0] cur_pend; // This frame goes on probation
	logic [`TTV_NTRK-1:0] prev_final; // Final verdict of previous frame
	ttv_entry_t rd_ent; // Entry waiting to be presented

	// Frame duration from the record rate
	always_comb begin
		unique case (RATE_SEL_I)
			`TTV_RATE_FAST: step = `TTV_STEP_FAST; // [RL2]
			`TTV_RATE_MID: step = `TTV_STEP_MID; // [RL2]
			`TTV_RATE_SLOW: step = `TTV_STEP_SLOW; // [RL2]
			default: step = `TTV_STEP_FAST;
		endcase
	end

	// Sync word or enabled watchdog moves time one frame on
	assign advance = SYNC_DET_I | (WDOG_EXP_I & WDOG_EN_I); // [RL2]

	// Per-track judgement
	genvar t;
	generate
		for (t = 0; t < `TTV_NTRK; t++) begin : g_trk
			// Sync accepted with a few bit errors
			assign sync_seen[t] = SYNC_FOUND_I[t] &
				(SYNC_BIT_ERR_I[t*`TTV_SERR_W +: `TTV_SERR_W] <= `TTV_SYNC_ERR_MAX); // [RL16]
			// No clock slip: sync sits at the prediction
			assign sync_good[t] = sync_seen[t] & SYNC_ON_TIME_I[t]; // [RL15]
			// Other criteria, independent of sync
			assign base_ok[t] = st_ff.time_valid & TRACK_EN_I[t] & ~GLOBAL_INVALID_I // [RL15] [RL18]
				& (PAR_ERR_I[t*`TTV_CNT_W +: `TTV_CNT_W] < PAR_LIMIT_I); // [RL17]
			// Missing sync defers the verdict when probation is on
			assign cur_pend[t] = base_ok[t] & ~sync_seen[t] & PROBATION_EN_I; // [RL19]
			assign cur_valid[t] = base_ok[t] & sync_good[t]; // [RL13]
			// Probation ends after one frame: next sync decides
			assign prev_final[t] = st_ff.pend_flag[t] ? (st_ff.pend_valid[t] & sync_good[t])
				: st_ff.pend_valid[t]; // [RL19] [RL20]
		end
	endgenerate

	// Circular store of frame records
	ttv_frame_store u_store (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.ent_we_i(FRAME_DONE_I & ~CONT_LOST_I),
		.ent_idx_i(st_ff.wr_ptr),
		.ent_addr_i(st_ff.start),
		.ent_time_i(st_ff.filt),
		.vld_we_i(FRAME_DONE_I & ~CONT_LOST_I & st_ff.have_prev),
		.vld_idx_i(st_ff.prev_idx),
		.vld_i(prev_final),
		.rd_idx_i(st_ff.rd_ptr),
		.rd_o(rd_ent)
	);

	// Next-state logic for the whole tracker
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wr_load = 1'b0;
		nxt_st.fstart = 1'b0;
		nxt_st.rd_load = 1'b0;

		// Sync reloads write address and marks frame start
		if (SYNC_DET_I) begin
			nxt_st.wr_load = 1'b1; // [RL25]
			nxt_st.wr_addr = NEXT_SYNC_ADDR_I; // [RL25]
			nxt_st.start = NEXT_SYNC_ADDR_I; // [RL22]
		end

		// Filtered time advances only once established
		if (advance && st_ff.tst != TTV_SEARCH) begin
			nxt_st.filt = st_ff.filt + step; // [RL2]
		end

		// Header results
		if (HDR_STB_I && HDR_OK_I) begin
			if (st_ff.tst == TTV_SEARCH) begin
				// First clean header sets time, probation starts
				nxt_st.filt = HDR_TIME_I; // [RL1] [RL6]
				nxt_st.tst = TTV_PROBATION; // [RL3]
				nxt_st.conf = '0;
				nxt_st.miss = '0;
				nxt_st.match = 1'b1;
			end else if (HDR_TIME_I == st_ff.filt) begin
				nxt_st.match = 1'b1; // [RL3]
			end
		end

		// End of a frame: confirm or count mismatch, file verdicts
		if (FRAME_DONE_I) begin
			nxt_st.match = 1'b0;
			if (st_ff.tst != TTV_SEARCH) begin
				if (st_ff.match) begin
					nxt_st.miss = '0; // [RL26]
					if (st_ff.tst == TTV_PROBATION) begin
						nxt_st.conf = st_ff.conf + 8'h01;
						// Valid after the programmed count of agreeing frames
						if (st_ff.conf + 8'h01 >= TIME_CONFIRM_COUNT_I) begin // [RL3] [RL4] [RL7]
							nxt_st.tst = TTV_LOCKED;
							nxt_st.time_valid = 1'b1;
						end
					end
				end else begin
					// Mismatch restarts confirmation
					if (st_ff.tst == TTV_PROBATION) begin
						nxt_st.conf = '0; // [RL26]
					end
					nxt_st.miss = st_ff.miss + 8'h01;
					// Too many mismatches: throw the time away
					if (st_ff.miss + 8'h01 >= TIME_MISMATCH_LIMIT_I) begin // [RL5] [RL7]
						nxt_st.tst = TTV_SEARCH; // [RL6]
						nxt_st.time_valid = 1'b0;
						nxt_st.conf = '0;
						nxt_st.miss = '0;
					end
				end
			end
			// This frame's record written; previous frame now final
			if (st_ff.have_prev) begin
				nxt_st.vld_ptr = st_ff.prev_idx + 4'h1; // [RL21]
			end
			nxt_st.prev_idx = st_ff.wr_ptr;
			nxt_st.wr_ptr = st_ff.wr_ptr + 4'h1; // [RL21]
			nxt_st.have_prev = 1'b1;
			nxt_st.pend_flag = cur_pend; // [RL19]
			nxt_st.pend_valid = cur_valid | cur_pend; // [RL14]
		end

		// Present the next frame when its first bit is read out
		if (st_ff.rd_ptr != st_ff.vld_ptr && RD_ADDR_I == rd_ent.addr) begin
			nxt_st.fstart = 1'b1; // [RL24]
			nxt_st.fvalid = rd_ent.valid; // [RL21]
			nxt_st.ftime = rd_ent.tcode; // [RL22]
			nxt_st.faddr = rd_ent.addr;
			nxt_st.rd_ptr = st_ff.rd_ptr + 4'h1;
		end

		// New delay read address every delay period
		if (DELAY_TICK_I) begin
			nxt_st.rd_load = 1'b1; // [RL23]
			nxt_st.rd_addr = DELAY_ADDR_I; // [RL23]
		end

		// Continuity lost: back to the start condition
		if (CONT_LOST_I) begin
			nxt_st.tst = TTV_SEARCH; // [RL11]
			nxt_st.time_valid = 1'b0;
			nxt_st.conf = '0;
			nxt_st.miss = '0;
			nxt_st.match = 1'b0;
			nxt_st.wr_ptr = '0;
			nxt_st.vld_ptr = '0;
			nxt_st.rd_ptr = '0;
			nxt_st.have_prev = 1'b0;
			nxt_st.pend_flag = '0;
			nxt_st.pend_valid = '0;
			nxt_st.fvalid = '0;
		end
	end

	// State register
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign FILT_TIME_O = st_ff.filt;
	assign TIME_VALID_O = st_ff.time_valid;
	assign WR_LOAD_O = st_ff.wr_load;
	assign WR_ADDR_O = st_ff.wr_addr;
	assign FRAME_START_O = st_ff.fstart;
	assign FRAME_VALID_O = st_ff.fvalid;
	assign FRAME_TIME_O = st_ff.ftime;
	assign FRAME_ADDR_O = st_ff.faddr;
	assign RD_LOAD_O = st_ff.rd_load;
	assign RD_ADDR_O = st_ff.rd_addr;

endmodule : ttv_tracker
`default_nettype wire

// *** dv/ttv_tracker_props.sv ***
/*
 Port checks for the tape time tracker.
 Assumes one clock and binding to ttv_tracker.
*/
`default_nettype none
`include "ttv_cfg.svh"
module ttv_tracker_chk (
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic SYNC_DET_I,
	input wire logic WDOG_EXP_I,
	input wire logic WDOG_EN_I,
	input wire logic [15:0] NEXT_SYNC_ADDR_I,
	input wire logic HDR_STB_I,
	input wire logic FRAME_DONE_I,
	input wire logic CONT_LOST_I,
	input wire logic [1:0] RATE_SEL_I,
	input wire logic DELAY_TICK_I,
	input wire logic [15:0] DELAY_ADDR_I,
	input wire logic [15:0] RD_ADDR_I,
	input wire logic [31:0] FILT_TIME_O,
	input wire logic TIME_VALID_O,
	input wire logic WR_LOAD_O,
	input wire logic [15:0] WR_ADDR_O,
	input wire logic FRAME_START_O,
	input wire logic [15:0] FRAME_ADDR_O,
	input wire logic RD_LOAD_O,
	input wire logic [15:0] RD_ADDR_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// Frame duration in ticks for a rate code
	function automatic logic [31:0] stp(input logic [1:0] r);
		return r == `TTV_RATE_MID ? `TTV_STEP_MID : r == `TTV_RATE_SLOW ? `TTV_STEP_SLOW : `TTV_STEP_FAST;
	endfunction : stp
	a_wr_load: assert property (SYNC_DET_I && !CONT_LOST_I |=> WR_LOAD_O && WR_ADDR_O == $past(NEXT_SYNC_ADDR_I))
		else $error("write load missing");
	a_wr_quiet: assert property (!SYNC_DET_I |=> !WR_LOAD_O)
		else $error("spurious write load");
	a_rd_load: assert property (DELAY_TICK_I |=> RD_LOAD_O && RD_ADDR_O == $past(DELAY_ADDR_I))
		else $error("read load missing");
	a_time_step: assert property ((SYNC_DET_I || WDOG_EXP_I && WDOG_EN_I) && TIME_VALID_O && !HDR_STB_I
		&& !FRAME_DONE_I && !CONT_LOST_I |=> FILT_TIME_O == $past(FILT_TIME_O) + stp($past(RATE_SEL_I)))
		else $error("time step wrong");
	a_time_hold: assert property (!SYNC_DET_I && !(WDOG_EXP_I && WDOG_EN_I) && !HDR_STB_I
		&& !FRAME_DONE_I && !CONT_LOST_I |=> $stable(FILT_TIME_O))
		else $error("time moved idle");
	a_start_addr: assert property (FRAME_START_O |-> FRAME_ADDR_O == $past(RD_ADDR_I))
		else $error("frame start off address");
	a_confirm_rise: assert property ($rose(TIME_VALID_O) |-> $past(FRAME_DONE_I))
		else $error("valid rose off frame");
	a_discard_fall: assert property ($fell(TIME_VALID_O) |-> $past(FRAME_DONE_I) || $past(CONT_LOST_I))
		else $error("valid fell off frame");
endmodule : ttv_tracker_chk
bind ttv_tracker ttv_tracker_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .SYNC_DET_I(SYNC_DET_I),
	.WDOG_EXP_I(WDOG_EXP_I), .WDOG_EN_I(WDOG_EN_I), .NEXT_SYNC_ADDR_I(NEXT_SYNC_ADDR_I), .HDR_STB_I(HDR_STB_I),
	.FRAME_DONE_I(FRAME_DONE_I), .CONT_LOST_I(CONT_LOST_I), .RATE_SEL_I(RATE_SEL_I), .DELAY_TICK_I(DELAY_TICK_I),
	.DELAY_ADDR_I(DELAY_ADDR_I), .RD_ADDR_I(RD_ADDR_I), .FILT_TIME_O(FILT_TIME_O), .TIME_VALID_O(TIME_VALID_O),
	.WR_LOAD_O(WR_LOAD_O), .WR_ADDR_O(WR_ADDR_O), .FRAME_START_O(FRAME_START_O), .FRAME_ADDR_O(FRAME_ADDR_O),
	.RD_LOAD_O(RD_LOAD_O), .RD_ADDR_O(RD_ADDR_O));
`default_nettype wire

// *** dv/ttv_dfm_model.sv ***
/*
 Deformatter-side model: read counter and frame start capture.
 Assumes the tracker shares its clock.
*/
`default_nettype none
module ttv_dfm_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rd_load_i,
	input wire logic [15:0] rd_addr_i,
	input wire logic frame_start_i,
	input wire logic [8:0] frame_valid_i,
	input wire logic [31:0] frame_time_i,
	input wire logic [15:0] frame_addr_i,
	input wire logic time_valid_i,
	input wire logic [31:0] filt_time_i,
	input wire logic dfm_invalid_i,
	output logic [15:0] rd_ptr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] TICKS_PER_DAY = 32'd172800000; // One day in 0.5 ms ticks
	localparam logic [31:0] NYQ_PER_TICK = 32'd8000; // Samples per tick, plain default
	logic [56:0] seen_q[$]; // Records taken at each start pulse
	logic [31:0] day_number; // Day of the filtered time
	logic [31:0] model_day; // Day of the delay model
	logic [63:0] nyq_count; // Samples since midnight
	logic centred; // Read point near buffer centre
	logic cycle_ok; // Per-cycle validity
	assign model_day = 32'h0;
	// Time conversion and per-cycle validity gating
	always_comb begin
		day_number = filt_time_i / TICKS_PER_DAY;
		nyq_count = 64'(filt_time_i % TICKS_PER_DAY) * 64'(NYQ_PER_TICK);
		centred = (rd_ptr_o - frame_addr_i) < 16'h8000;
		cycle_ok = time_valid_i && day_number == model_day && (&frame_valid_i)
			&& centred && !dfm_invalid_i;
	end
	// Read counter steps each cycle, jumps on a delay load
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rd_ptr_o <= 16'h0;
		else if (rd_load_i) rd_ptr_o <= rd_addr_i;
		else rd_ptr_o <= rd_ptr_o + 16'h1;
	end
	// Validity sampled with the shared start pulse
	always @(posedge clk_i) begin
		if (frame_start_i) seen_q.push_back({frame_time_i, frame_addr_i, frame_valid_i});
	end
endmodule : ttv_dfm_model
`default_nettype wire

// *** dv/tb_top.sv ***
/*
 Bench for the tracker: random frames, lock, discard, restart, readout.
 Assumes the checker is bound and the model drives read addresses.
*/
`default_nettype none
`include "ttv_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, sdet = 0, wexp = 0, wen = 0, hstb = 0, hok = 0, fdone = 0;
	logic ginv = 0, pen = 0, clost = 0, dtick = 0, tv_o, fst, rld, tv = 0, hp = 0;
	logic [1:0] rate = 0;
	logic [8:0] ten = 0, sfnd = 0, sont = 0, fval, pgood = 0, pdef = 0;
	logic [15:0] nsa = 0, dad = 0, rdad, fad, rad, pa = 0;
	logic [31:0] htime = 0, rnd = 32'h1e94, ft_o, ftim, ft = 0, pt = 0;
	logic [35:0] serr = 0;
	logic [71:0] perr = 0;
	logic [7:0] plim = 0, ccnt = 0, mlim = 0;
	int err_count = 0, num_checks = 0, st = 0, conf = 0, mis = 0; // Counters and expected tracker state
	ttv_tracker dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .TRACK_EN_I(ten), .RATE_SEL_I(rate), .SYNC_DET_I(sdet),
		.WDOG_EXP_I(wexp), .WDOG_EN_I(wen), .NEXT_SYNC_ADDR_I(nsa), .HDR_STB_I(hstb), .HDR_OK_I(hok),
		.HDR_TIME_I(htime), .FRAME_DONE_I(fdone), .SYNC_FOUND_I(sfnd), .SYNC_BIT_ERR_I(serr),
		.SYNC_ON_TIME_I(sont), .PAR_ERR_I(perr), .PAR_LIMIT_I(plim), .TIME_CONFIRM_COUNT_I(ccnt),
		.TIME_MISMATCH_LIMIT_I(mlim), .GLOBAL_INVALID_I(ginv), .PROBATION_EN_I(pen), .CONT_LOST_I(clost),
		.RD_ADDR_I(rdad), .DELAY_TICK_I(dtick), .DELAY_ADDR_I(dad), .FILT_TIME_O(ft_o), .TIME_VALID_O(tv_o),
		.WR_LOAD_O(), .WR_ADDR_O(), .FRAME_START_O(fst), .FRAME_VALID_O(fval), .FRAME_TIME_O(ftim),
		.FRAME_ADDR_O(fad), .RD_LOAD_O(rld), .RD_ADDR_O(rad));
	ttv_dfm_model dfm (.clk_i(clk), .rst_n_i(rst_n), .rd_load_i(rld), .rd_addr_i(rad), .frame_start_i(fst),
		.frame_valid_i(fval), .frame_time_i(ftim), .frame_addr_i(fad), .time_valid_i(tv_o),
		.filt_time_i(ft_o), .dfm_invalid_i(ginv), .rd_ptr_o(rdad));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] stp(input logic [1:0] r);
		return r == `TTV_RATE_MID ? `TTV_STEP_MID : r == `TTV_RATE_SLOW ? `TTV_STEP_SLOW : `TTV_STEP_FAST;
	endfunction : stp
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	// One frame: sync, header, watchdog, verdict inputs, readout of the previous frame
	task automatic frame(input int f);
		logic [8:0] fd, on, sg, good, dfr, fin;
		logic [35:0] be;
		logic [71:0] pe;
		logic [31:0] t;
		logic fine, m, gi, pn;
		@(posedge clk);
		rate <= 2'(f);
		sdet <= 1;
		nsa <= 16'(256 + f * 64);
		@(posedge clk);
		sdet <= 0;
		if (st != 0) ft += stp(rate);
		rnd = lfsr(rnd);
		t = st == 0 ? rnd : ft + 32'(f == 12 || (f >= 16 && f < 16 + mlim) || f == 17 + mlim);
		hstb <= 1;
		hok <= f >= 2;
		htime <= t;
		if (f >= 2 && st == 0) begin
			ft = t;
			st = 1;
			conf = 0;
			mis = 0;
		end
		m = f >= 2 && t == ft;
		@(posedge clk);
		hstb <= 0;
		wexp <= 1;
		wen <= rnd[3];
		if (rnd[3] && st != 0) ft += stp(rate);
		gi = f == 26 || f == 27;
		pn = rnd[9];
		for (int i = 0; i < 9; i++) begin
			rnd = lfsr(rnd);
			fd[i] = rnd[2:0] != 3'h0;
			on[i] = rnd[5:3] != 3'h0;
			be[i*4+:4] = {2'h0, rnd[7:6]};
			pe[i*8+:8] = {3'h0, rnd[12:8]};
			fine = tv && ten[i] && !gi && pe[i*8+:8] < plim;
			sg[i] = fd[i] && rnd[7:6] <= 2'h2 && on[i];
			good[i] = fine && sg[i];
			dfr[i] = pn && fine && !(fd[i] && rnd[7:6] <= 2'h2);
		end
		fin = pdef & sg | ~pdef & pgood;
		@(posedge clk);
		wexp <= 0;
		sfnd <= fd;
		sont <= on;
		serr <= be;
		perr <= pe;
		ginv <= gi;
		pen <= pn;
		clost <= f == 32;
		fdone <= 1;
		@(posedge clk);
		fdone <= 0;
		clost <= 0;
		if (f == 32) begin
			st = 0;
			tv = 0;
		end else begin
			mis = m ? 0 : mis + 1;
			if (st == 1) conf = m ? conf + 1 : 0;
			if (st == 1 && conf >= ccnt) begin
				st = 2;
				tv = 1;
			end
			if (st != 0 && mis >= mlim) begin
				st = 0;
				tv = 0;
			end
		end
		@(negedge clk);
		if (st != 0) chk(ft_o, ft);
		if (f != 32) chk(tv_o, tv);
		if (hp && f != 32) begin
			@(posedge clk);
			dtick <= 1;
			dad <= pa - 16'h2;
			@(posedge clk);
			dtick <= 0;
			for (int w = 0; w < 12 && dfm.seen_q.size() == 0; w++) @(posedge clk);
			chk(dfm.seen_q.pop_front(), {pt, pa, fin});
		end
		hp = f != 32;
		pt = ft;
		pa = 16'(256 + f * 64);
		pgood = good;
		pdef = dfr;
	endtask : frame
	initial forever #12.5 clk = ~clk;
	// Main sequence: settings, reset, frames
	initial begin
		rnd = lfsr(rnd);
		ten = rnd[8:0] | 9'h101;
		plim = 8'(12 + rnd[14:12]);
		ccnt = 8'(2 + rnd[10:9] % 3);
		mlim = 8'(2 + rnd[11]);
		repeat (8) @(posedge clk);
		rst_n <= 1;
		for (int f = 0; f < 40; f++) frame(f);
		test_done();
	end
	// Hang guard, well beyond forty frames
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
